/* File: hw/icc_capture_ctrl.sv */
// Overview of operation
// - Bits 6,5,4 of the enable/flag register enable channels 2,1,0; 1 enables.
// - Hardware sets flag bits 2,1,0 when the channel's selected edge appears.
// - Flags stay set until software writes zero; hardware never clears them.
// - Edge code 00 falling, 01 rising, 10 both edges; 11 detects nothing.
// - Edge fields at bits 5:4, 3:2, 1:0 of the edge register; 11 reserved.
// - Capture registers reachable only while page select holds 0.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "icc_regs.svh"

module icc_capture_ctrl
  import icc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Capture pins
  input wire logic [2:0] cap_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Interrupt
  output logic irq
);

  icc_state_t st;
  icc_state_t next_st;
  logic [2:0] ev;
  logic wr_commit;
  icc_reg_t wr_reg;
  icc_reg_t rd_reg;
  logic rd_take;

  // Capture registers answer only on their own page; elsewhere they read zero
  function automatic icc_reg_t reg_decode(input logic [9:0] idx, input logic [1:0] pg);
    icc_reg_t r;
    r = ICC_REG_NONE;
    case (idx)
      `ICC_IDX_PAGE: r = ICC_REG_PAGE;
      `ICC_IDX_CTL0: r = (pg == `ICC_CAP_PAGE) ? ICC_REG_CTL0 : ICC_REG_OFFPG;
      `ICC_IDX_CTL1: r = (pg == `ICC_CAP_PAGE) ? ICC_REG_CTL1 : ICC_REG_OFFPG;
      `ICC_IDX_ISTAT: r = ICC_REG_ISTAT;
      `ICC_IDX_IMASK: r = ICC_REG_IMASK;
      default: r = ICC_REG_NONE;
    endcase
    return r;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                    input logic cur);
    logic h;
    h = 1'b0;
    case (icc_edge_t'(sel))
      ICC_EDGE_FALL: h = prev & ~cur;
      ICC_EDGE_RISE: h = ~prev & cur;
      ICC_EDGE_BOTH: h = prev ^ cur;
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  function automatic logic [7:0] read_value(input icc_reg_t r, input icc_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (r)
      ICC_REG_PAGE: v[`ICC_PAGE_LSB +: 2] = s.page;
      ICC_REG_CTL0: begin
        v[`ICC_EN_LSB +: 3] = s.cap.en;
        v[`ICC_FLAG_LSB +: 3] = s.cap.flag;
      end
      ICC_REG_CTL1: v[`ICC_SEL_LSB +: 6] = s.cap.sel;
      ICC_REG_ISTAT: v[2:0] = s.istat;
      ICC_REG_IMASK: v[2:0] = s.imask;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign wr_reg = reg_decode(st.wr.idx, st.page);
  assign rd_reg = reg_decode(s_axi_araddr[11:2], st.page);
  assign wr_commit = (st.wr.state == ICC_CH_IDLE) && st.wr.aw_got && st.wr.w_got;
  assign rd_take = s_axi_arvalid && st.rd.arready;

  always_comb begin
    next_st = st;

    // The first cycle after reset only loads the pin history, so a pin that
    // is already high at release is not mistaken for an edge.
    next_st.cap.armed = 1'b1;
    next_st.cap.prev = cap_in;
    for (int i = 0; i < 3; i++) begin
      ev[i] = st.cap.armed && st.cap.en[i] &&
              edge_hit(st.cap.sel[2*i +: 2], st.cap.prev[i], cap_in[i]);
    end

    // Write channel: address and data may arrive in either order
    if (s_axi_awvalid && st.wr.awready) begin
      next_st.wr.aw_got = 1'b1;
      next_st.wr.idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && st.wr.wready) begin
      next_st.wr.w_got = 1'b1;
      next_st.wr.data = s_axi_wdata[7:0];
      next_st.wr.strb0 = s_axi_wstrb[0];
    end

    case (st.wr.state)
      ICC_CH_IDLE: begin
        if (wr_commit) begin
          next_st.wr.state = ICC_CH_RESP;
          next_st.wr.aw_got = 1'b0;
          next_st.wr.w_got = 1'b0;
          next_st.wr.bvalid = 1'b1;
          next_st.wr.bresp = (wr_reg == ICC_REG_NONE) ? `ICC_RESP_DECERR
                                                      : `ICC_RESP_OKAY;
          if (st.wr.strb0) begin
            case (wr_reg)
              ICC_REG_PAGE: next_st.page = st.wr.data[`ICC_PAGE_LSB +: 2];
              ICC_REG_CTL0: begin
                next_st.cap.en = st.wr.data[`ICC_EN_LSB +: 3];
                // Zero clears flag; writing one leaves it alone
                next_st.cap.flag = st.cap.flag & st.wr.data[`ICC_FLAG_LSB +: 3];
              end
              ICC_REG_CTL1: next_st.cap.sel = st.wr.data[`ICC_SEL_LSB +: 6];
              ICC_REG_IMASK: next_st.imask = st.wr.data[2:0];
              default: next_st.page = st.page;
            endcase
          end
        end
      end
      ICC_CH_RESP: begin
        if (s_axi_bready) begin
          next_st.wr.state = ICC_CH_IDLE;
          next_st.wr.bvalid = 1'b0;
        end
      end
      default: begin
        next_st.wr.state = ICC_CH_IDLE;
        next_st.wr.bvalid = 1'b0;
      end
    endcase
    next_st.wr.awready = !next_st.wr.aw_got && (next_st.wr.state == ICC_CH_IDLE);
    next_st.wr.wready = !next_st.wr.w_got && (next_st.wr.state == ICC_CH_IDLE);

    // Read channel; the status register is cleared by the read that takes it
    case (st.rd.state)
      ICC_CH_IDLE: begin
        if (rd_take) begin
          next_st.rd.state = ICC_CH_RESP;
          next_st.rd.rvalid = 1'b1;
          next_st.rd.data = read_value(rd_reg, st);
          next_st.rd.rresp = (rd_reg == ICC_REG_NONE) ? `ICC_RESP_DECERR
                                                      : `ICC_RESP_OKAY;
          if (rd_reg == ICC_REG_ISTAT) begin
            next_st.istat = 3'h0;
          end
        end
      end
      ICC_CH_RESP: begin
        if (s_axi_rready) begin
          next_st.rd.state = ICC_CH_IDLE;
          next_st.rd.rvalid = 1'b0;
        end
      end
      default: begin
        next_st.rd.state = ICC_CH_IDLE;
        next_st.rd.rvalid = 1'b0;
      end
    endcase
    next_st.rd.arready = (next_st.rd.state == ICC_CH_IDLE);

    // Set wins over a clear in the same cycle
    next_st.cap.flag = next_st.cap.flag | ev;
    next_st.istat = next_st.istat | ev;
    next_st.irq = |(next_st.istat & next_st.imask);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st.page <= `ICC_RST_PAGE;
      st.cap.armed <= 1'b0;
      st.cap.en <= `ICC_RST_EN;
      st.cap.flag <= `ICC_RST_FLAG;
      st.cap.sel <= `ICC_RST_SEL;
      st.cap.prev <= 3'h0;
      st.istat <= `ICC_RST_IRQ;
      st.imask <= `ICC_RST_IRQ;
      st.irq <= 1'b0;
      st.wr.state <= ICC_CH_IDLE;
      st.wr.aw_got <= 1'b0;
      st.wr.w_got <= 1'b0;
      st.wr.idx <= 10'h000;
      st.wr.data <= 8'h00;
      st.wr.strb0 <= 1'b0;
      st.wr.awready <= 1'b0;
      st.wr.wready <= 1'b0;
      st.wr.bvalid <= 1'b0;
      st.wr.bresp <= `ICC_RESP_OKAY;
      st.rd.state <= ICC_CH_IDLE;
      st.rd.arready <= 1'b0;
      st.rd.rvalid <= 1'b0;
      st.rd.data <= 8'h00;
      st.rd.rresp <= `ICC_RESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.wr.awready;
  assign s_axi_wready = st.wr.wready;
  assign s_axi_bvalid = st.wr.bvalid;
  assign s_axi_bresp = st.wr.bresp;
  assign s_axi_arready = st.rd.arready;
  assign s_axi_rvalid = st.rd.rvalid;
  assign s_axi_rdata = {24'h00_0000, st.rd.data};
  assign s_axi_rresp = st.rd.rresp;
  assign irq = st.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence

  sequence w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence

  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence ctl0_commit;
    wr_commit && st.wr.strb0 && (wr_reg == ICC_REG_CTL0);
  endsequence

  property answer_after_both;
    aw_taken and w_taken |-> ##[1:2] s_axi_bvalid;
  endproperty

  write_answer_a: assert property (answer_after_both)
    else $error("write response missing after address and data");

  rise_flag_a: assert property (
    st.cap.armed && st.cap.en[0] && (st.cap.sel[1:0] == ICC_EDGE_RISE) &&
    !st.cap.prev[0] && cap_in[0] |=> st.cap.flag[0] && st.istat[0])
    else $error("rising edge did not set channel 0 flag");

  both_flag_a: assert property (
    st.cap.armed && st.cap.en[2] && (st.cap.sel[5:4] == ICC_EDGE_BOTH) &&
    (st.cap.prev[2] != cap_in[2]) |=> st.cap.flag[2])
    else $error("either-edge mode missed an edge on channel 2");

  flag_hold_a: assert property (
    st.cap.flag[1] && !(wr_commit && st.wr.strb0 && (wr_reg == ICC_REG_CTL0) &&
    !st.wr.data[1]) |=> st.cap.flag[1])
    else $error("channel 1 flag dropped without a clearing write");

  disabled_quiet_a: assert property (
    !st.cap.en[0] && !st.cap.flag[0] |=> !st.cap.flag[0])
    else $error("disabled channel 0 set its flag");

  enable_write_a: assert property (
    ctl0_commit |=> st.cap.en == $past(st.wr.data[6:4]))
    else $error("enable bits not taken from the write");

  sel_write_a: assert property (
    wr_commit && st.wr.strb0 && (wr_reg == ICC_REG_CTL1)
    |=> st.cap.sel == $past(st.wr.data[5:0]))
    else $error("edge fields not taken from the write");

  page_gate_a: assert property (
    wr_commit && (st.wr.idx == `ICC_IDX_CTL0) && (st.page != `ICC_CAP_PAGE)
    |=> $stable(st.cap.en))
    else $error("capture register written while another page was selected");

  irq_level_a: assert property (
    st.irq == |(st.istat & st.imask))
    else $error("interrupt output disagrees with status and mask");

  read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data not offered the cycle after the address");

  // One transfer per direction: the handshake stays shut until answered
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels ready while a response is pending");

  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data is pending");

  fall_flag_a: assert property (
    st.cap.armed && st.cap.en[1] && (st.cap.sel[3:2] == ICC_EDGE_FALL) &&
    st.cap.prev[1] && !cap_in[1] |=> st.cap.flag[1])
    else $error("falling edge did not set channel 1 flag");

  page_read_a: assert property (
    rd_take && (s_axi_araddr[11:2] == `ICC_IDX_CTL0) && (st.page != `ICC_CAP_PAGE)
    |=> s_axi_rdata == 32'h0000_0000)
    else $error("capture register read back on another page");

  // An event in the read cycle wins, so only quiet cycles are checked here
  status_clear_a: assert property (
    rd_take && (rd_reg == ICC_REG_ISTAT) && !(|ev) |=> st.istat == 3'h0)
    else $error("status read did not clear the status bits");

  // A mask write in the same cycle may keep the line low on purpose
  irq_set_a: assert property (
    ev[0] && st.imask[0] && !(wr_commit && (wr_reg == ICC_REG_IMASK)) |=> irq)
    else $error("unmasked event did not raise the interrupt");

endmodule
`default_nettype wire

/* File: hw/icc_pkg.sv */
`default_nettype none
package icc_pkg;

  typedef enum logic [1:0] {
    ICC_EDGE_FALL = 2'h0,
    ICC_EDGE_RISE = 2'h1,
    ICC_EDGE_BOTH = 2'h2,
    ICC_EDGE_RSVD = 2'h3
  } icc_edge_t;

  typedef enum logic [1:0] {
    ICC_CH_IDLE = 2'b01,
    ICC_CH_RESP = 2'b10
  } icc_chan_t;

  typedef enum logic [2:0] {
    ICC_REG_NONE,
    ICC_REG_OFFPG,
    ICC_REG_PAGE,
    ICC_REG_CTL0,
    ICC_REG_CTL1,
    ICC_REG_ISTAT,
    ICC_REG_IMASK
  } icc_reg_t;

  typedef struct packed {
    logic armed;
    logic [2:0] en;
    logic [2:0] flag;
    logic [5:0] sel;
    logic [2:0] prev;
  } icc_cap_t;

  typedef struct packed {
    icc_chan_t state;
    logic aw_got;
    logic w_got;
    logic [9:0] idx;
    logic [7:0] data;
    logic strb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
  } icc_wr_t;

  typedef struct packed {
    icc_chan_t state;
    logic arready;
    logic rvalid;
    logic [7:0] data;
    logic [1:0] rresp;
  } icc_rd_t;

  typedef struct packed {
    logic [1:0] page;
    icc_cap_t cap;
    logic [2:0] istat;
    logic [2:0] imask;
    logic irq;
    icc_wr_t wr;
    icc_rd_t rd;
  } icc_state_t;

endpackage
`default_nettype wire

/* File: hw/icc_regs.svh */
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define ICC_IDX_PAGE 10'h091
`define ICC_IDX_CTL0 10'h092
`define ICC_IDX_CTL1 10'h093
`define ICC_IDX_ISTAT 10'h0a0
`define ICC_IDX_IMASK 10'h0a1

// Field positions
`define ICC_EN_LSB 4
`define ICC_FLAG_LSB 0
`define ICC_SEL_LSB 0
`define ICC_PAGE_LSB 0
`define ICC_CAP_PAGE 2'h0

// Reset values
`define ICC_RST_PAGE 2'h0
`define ICC_RST_EN 3'h0
`define ICC_RST_FLAG 3'h0
`define ICC_RST_SEL 6'h00
`define ICC_RST_IRQ 3'h0

// AXI responses
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_DECERR 2'h3

`endif

/* File: verification/icc_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Capture pins are plain levels held by the outside world until changed
module icc_pin_model (
  // Clock
  input wire logic ref_clk,
  // Pins
  output logic [2:0] cap_in
);
  initial cap_in = 3'h0;
  // Changes land just after an edge, so the design sees them on the next one
  task automatic drive(input int ch, input logic v);
    @(posedge ref_clk);
    cap_in[ch] <= v;
  endtask
endmodule
`default_nettype wire

/* File: verification/input_capture_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module input_capture_control_test;
  localparam logic [11:0] A_PG = 12'h244;
  localparam logic [11:0] A_C0 = 12'h248;
  localparam logic [11:0] A_C1 = 12'h24c;
  localparam logic [11:0] A_IS = 12'h280;
  localparam logic [11:0] A_IM = 12'h284;
  typedef struct {logic [1:0] sel; logic from; logic to; logic hit;} icc_row_t;
  logic ref_clk, rst, irq;
  logic [2:0] cap_in;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] d;
  int n_mismatch, n_compared;
  icc_row_t rows [6] = '{'{2'h0, 1'b1, 1'b0, 1'b1}, '{2'h0, 1'b0, 1'b1, 1'b0},
                         '{2'h1, 1'b0, 1'b1, 1'b1}, '{2'h1, 1'b1, 1'b0, 1'b0},
                         '{2'h2, 1'b0, 1'b1, 1'b1}, '{2'h2, 1'b1, 1'b0, 1'b1}};

  icc_pin_model pins (.ref_clk(ref_clk), .cap_in(cap_in));
  icc_capture_ctrl dut (.ref_clk, .rst, .cap_in, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'h1), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .irq);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    int n;
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) chk(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) chk(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run needs well under 3000 cycles
  initial begin
    #(50 * 20000);
    n_mismatch++;
    final_report();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    rst = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(A_C0);
    chk(d, 32'h0000_0000);
    rd(A_C1);
    chk(d, 32'h0000_0000);
    rd(A_PG);
    chk(d, 32'h0000_0000);
    // Edge codes 00, 01 and 10 on each channel, flags cleared just before the edge
    foreach (rows[i]) begin
      for (int ch = 0; ch < 3; ch++) begin
        wr(A_C1, {2'h0, rows[i].sel, rows[i].sel, rows[i].sel});
        pins.drive(ch, rows[i].from);
        repeat (3) @(posedge ref_clk);
        wr(A_C0, 8'h70);
        pins.drive(ch, rows[i].to);
        repeat (3) @(posedge ref_clk);
        rd(A_C0);
        chk(d, 32'h0000_0070 | (32'(rows[i].hit) << ch));
      end
    end
    // Flag survives idle time and a write of one, only a zero clears it
    repeat (20) @(posedge ref_clk);
    wr(A_C0, 8'h74);
    rd(A_C0);
    chk(d, 32'h0000_0074);
    wr(A_C0, 8'h70);
    rd(A_C0);
    chk(d, 32'h0000_0070);
    // Disabled channels ignore their pins
    wr(A_C0, 8'h00);
    pins.drive(0, 1'b1);
    pins.drive(1, 1'b1);
    repeat (3) @(posedge ref_clk);
    rd(A_C0);
    chk(d, 32'h0000_0000);
    // Other pages hide the capture registers
    for (int p = 1; p < 3; p++) begin
      wr(A_PG, 8'(p));
      chk({30'h0, r}, 32'h0000_0000);
      rd(A_C0);
      chk(d, 32'h0000_0000);
      wr(A_C0, 8'h70);
      rd(A_PG);
      chk(d, 32'(p));
    end
    wr(A_PG, 8'h00);
    rd(A_C0);
    chk(d, 32'h0000_0000);
    // Interrupt raised, cleared by status read, then masked
    rd(A_IS);
    wr(A_IM, 8'h07);
    rd(A_IM);
    chk(d, 32'h0000_0007);
    wr(A_C0, 8'h10);
    pins.drive(0, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(A_IS);
    chk(d, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(A_IM, 8'h00);
    pins.drive(0, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(A_IS);
    chk(d, 32'h0000_0001);
    // Unmapped addresses answer with a decode error and read zero
    rd(12'h000);
    chk({30'h0, r}, 32'h0000_0003);
    chk(d, 32'h0000_0000);
    wr(12'h000, 8'h00);
    chk({30'h0, r}, 32'h0000_0003);
    // Reset in mid-run, with the interrupt up, brings CTL0, mask and status registers back
    wr(A_IM, 8'h07);
    pins.drive(0, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0000_0001);
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk({28'h0, s_axi_awready, s_axi_wready, s_axi_arready, irq}, 32'h0000_0000);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(A_C0);
    chk(d, 32'h0000_0000);
    rd(A_IM);
    chk(d, 32'h0000_0000);
    rd(A_IS);
    chk(d, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
